// *** spt_cfg.svh ***
// Constants for the split 8-bit auto-reload timer.
`ifndef SPT_CFG_SVH
`define SPT_CFG_SVH
`define SPT_ADDR_CTRL     4'h0
`define SPT_ADDR_CLOCK_CONTROL_REG    4'h1
`define SPT_ADDR_RLL      4'h2
`define SPT_ADDR_RLH      4'h3
`define SPT_ADDR_CNTL     4'h4
`define SPT_ADDR_CNTH     4'h5
`define SPT_ADDR_IE       4'h6
`define SPT_CTRL_TFH      7
`define SPT_CTRL_TFL      6
`define SPT_CTRL_LEN      5
`define SPT_CTRL_SPLIT    3
`define SPT_CTRL_RUN      2
`define SPT_CTRL_XCLK_HI  1
`define SPT_CTRL_XCLK_LO  0
`define SPT_CK_HI         1
`define SPT_CK_LO         0
`define SPT_IE_TMR        0
`define SPT_CTRL_RST      8'h00
`define SPT_BYTE_RST      8'h00
`define SPT_BYTE_MAX      8'hFF
`define SPT_DIV12_LAST    4'hB
`define SPT_DIV8_LAST     3'h7
`endif

// *** spt_pkg.sv ***
// Types for the split 8-bit auto-reload timer.
`default_nettype none
package spt_pkg;
   typedef enum logic [1:0] {
      SPT_XS_DIV12 = 2'h0,
      SPT_XS_RTC8  = 2'h1,
      SPT_XS_RSVD  = 2'h2,
      SPT_XS_CMP0  = 2'h3
   } spt_xsel_t;
   typedef logic [7:0] spt_byte_t;
   typedef logic [3:0] spt_addr_t;
endpackage : spt_pkg
`default_nettype wire

// *** spt_timer.sv ***
// Split-mode timer: two 8-bit auto-reload counters with register port and interrupt.
`include "spt_cfg.svh"
`default_nettype none
module spt_timer (
   input  wire logic           sys_clk,
   input  wire logic           rst_n,
   input  wire spt_pkg::spt_addr_t addr,
   input  wire spt_pkg::spt_byte_t wr_data,
   input  wire logic           wr_en,
   input  wire logic           rd_en,
   output var  spt_pkg::spt_byte_t rd_data,
   input  wire logic           rtc_clk_in,
   input  wire logic           cmp0_in,
   output logic                irq
);
   import spt_pkg::*;

   spt_byte_t  ctrl_reg;
   logic [1:0] clock_control_reg_reg;
   logic       ie_reg;
   spt_byte_t  rll_reg;
   spt_byte_t  rlh_reg;
   spt_byte_t  cntl_reg;
   spt_byte_t  cnth_reg;
   spt_byte_t  rd_data_reg;
   spt_byte_t  rd_data_next;
   logic [3:0] div12_reg;
   logic [2:0] div8_reg;
   logic [1:0] rtc_sync_reg;
   logic [1:0] cmp_sync_reg;
   logic       rtc_prev_reg;
   logic       cmp_prev_reg;

   wire sel_ctrl  = addr == `SPT_ADDR_CTRL;
   wire sel_clock_control_reg = addr == `SPT_ADDR_CLOCK_CONTROL_REG;
   wire sel_rll   = addr == `SPT_ADDR_RLL;
   wire sel_rlh   = addr == `SPT_ADDR_RLH;
   wire sel_cntl  = addr == `SPT_ADDR_CNTL;
   wire sel_cnth  = addr == `SPT_ADDR_CNTH;
   wire sel_ie    = addr == `SPT_ADDR_IE;

   wire       split_mode_select = ctrl_reg[`SPT_CTRL_SPLIT];
   wire       run_control       = ctrl_reg[`SPT_CTRL_RUN];
   wire       low_flag_irq_enable = ctrl_reg[`SPT_CTRL_LEN];
   wire       timer_irq_enable  = ie_reg;
   spt_xsel_t ext_clock_select;
   assign ext_clock_select = spt_xsel_t'({ctrl_reg[`SPT_CTRL_XCLK_HI],
                                          ctrl_reg[`SPT_CTRL_XCLK_LO]});
   wire high_clock_select = clock_control_reg_reg[`SPT_CK_HI];
   wire low_clock_select  = clock_control_reg_reg[`SPT_CK_LO];

   // Prescalers free-run so both halves share one phase of each slow tick.
   wire tick_div12 = div12_reg == `SPT_DIV12_LAST;
   wire rtc_rise   = rtc_sync_reg[1] & ~rtc_prev_reg;
   wire tick_rtc8  = rtc_rise && div8_reg == `SPT_DIV8_LAST;
   wire cmp_rise   = cmp_sync_reg[1] & ~cmp_prev_reg;

   // The reserved field code never counts, so a stray setting stalls a half whose clock select bit is clear.
   wire ext_tick = (ext_clock_select == SPT_XS_DIV12) ? tick_div12 :
                   (ext_clock_select == SPT_XS_RTC8)  ? tick_rtc8  :
                   (ext_clock_select == SPT_XS_CMP0)  ? cmp_rise   : 1'b0;
   wire tick_hi = high_clock_select ? 1'b1 : ext_tick;
   wire tick_lo = low_clock_select  ? 1'b1 : ext_tick;

   // Only split mode is implemented; with it clear both halves hold.
   wire step_hi = split_mode_select & run_control & tick_hi;
   wire step_lo = split_mode_select & tick_lo;
   wire ovf_hi  = step_hi && cnth_reg == `SPT_BYTE_MAX;
   wire ovf_lo  = step_lo && cntl_reg == `SPT_BYTE_MAX;

   wire wr_ctrl = wr_en & sel_ctrl;
   // Hardware set wins over a software clear in the same cycle.
   wire tfh_next = ovf_hi | (wr_ctrl ? wr_data[`SPT_CTRL_TFH] : ctrl_reg[`SPT_CTRL_TFH]);
   wire tfl_next = ovf_lo | (wr_ctrl ? wr_data[`SPT_CTRL_TFL] : ctrl_reg[`SPT_CTRL_TFL]);
   spt_byte_t ctrl_next;
   assign ctrl_next = {tfh_next, tfl_next,
                       wr_ctrl ? wr_data[5:0] : ctrl_reg[5:0]};

   spt_byte_t cnth_next;
   spt_byte_t cntl_next;
   assign cnth_next = ovf_hi ? rlh_reg :
                      (wr_en & sel_cnth) ? wr_data :
                      step_hi ? spt_byte_t'(cnth_reg + 8'h01) : cnth_reg;
   assign cntl_next = ovf_lo ? rll_reg :
                      (wr_en & sel_cntl) ? wr_data :
                      step_lo ? spt_byte_t'(cntl_reg + 8'h01) : cntl_reg;

   assign rd_data_next = !rd_en    ? `SPT_BYTE_RST :
                         sel_ctrl  ? ctrl_reg :
                         sel_clock_control_reg ? {6'h00, clock_control_reg_reg} :
                         sel_rll   ? rll_reg :
                         sel_rlh   ? rlh_reg :
                         sel_cntl  ? cntl_reg :
                         sel_cnth  ? cnth_reg :
                         sel_ie    ? {7'h00, ie_reg} : `SPT_BYTE_RST;
   assign rd_data = rd_data_reg;

   assign irq = timer_irq_enable & (ctrl_reg[`SPT_CTRL_TFH] |
                (low_flag_irq_enable & ctrl_reg[`SPT_CTRL_TFL]));

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rtc_sync_reg <= 2'h0;
         cmp_sync_reg <= 2'h0;
         rtc_prev_reg <= 1'b0;
         cmp_prev_reg <= 1'b0;
      end else begin
         rtc_sync_reg <= {rtc_sync_reg[0], rtc_clk_in};
         cmp_sync_reg <= {cmp_sync_reg[0], cmp0_in};
         rtc_prev_reg <= rtc_sync_reg[1];
         cmp_prev_reg <= cmp_sync_reg[1];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div12_reg <= 4'h0;
         div8_reg  <= 3'h0;
      end else begin
         div12_reg <= tick_div12 ? 4'h0 : div12_reg + 4'h1;
         if (rtc_rise) begin
            div8_reg <= div8_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg  <= `SPT_CTRL_RST;
         clock_control_reg_reg <= 2'h0;
         ie_reg    <= 1'b0;
         rll_reg   <= `SPT_BYTE_RST;
         rlh_reg   <= `SPT_BYTE_RST;
         cntl_reg  <= `SPT_BYTE_RST;
         cnth_reg  <= `SPT_BYTE_RST;
         rd_data_reg <= `SPT_BYTE_RST;
      end else begin
         ctrl_reg <= ctrl_next;
         cntl_reg <= cntl_next;
         cnth_reg <= cnth_next;
         rd_data_reg <= rd_data_next;
         if (wr_en & sel_clock_control_reg) begin
            clock_control_reg_reg <= wr_data[1:0];
         end
         if (wr_en & sel_ie) begin
            ie_reg <= wr_data[`SPT_IE_TMR];
         end
         if (wr_en & sel_rll) begin
            rll_reg <= wr_data;
         end
         if (wr_en & sel_rlh) begin
            rlh_reg <= wr_data;
         end
      end
   end

   // The checks below watch the counters, flags and interrupt against the register state.
   // Counter writes are excluded where they would legally move a counter.

   sequence s_low_step;
      split_mode_select && low_clock_select && !(wr_en && sel_cntl) && cntl_reg != `SPT_BYTE_MAX;
   endsequence

   sequence s_high_step;
      split_mode_select && run_control && high_clock_select && !(wr_en && sel_cnth) &&
         cnth_reg != `SPT_BYTE_MAX;
   endsequence

   sequence s_low_at_max;
      split_mode_select && low_clock_select && cntl_reg == `SPT_BYTE_MAX;
   endsequence

   sequence s_low_reloaded;
      cntl_reg == $past(rll_reg) && ctrl_reg[`SPT_CTRL_TFL];
   endsequence

   sequence s_high_at_max;
      split_mode_select && run_control && high_clock_select && cnth_reg == `SPT_BYTE_MAX;
   endsequence

   sequence s_high_reloaded;
      cnth_reg == $past(rlh_reg) && ctrl_reg[`SPT_CTRL_TFH];
   endsequence

   a_high_reload: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      ovf_hi |=> cnth_reg == $past(rlh_reg))
      else $error("High half did not reload.");

   a_low_reload: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      ovf_lo |=> cntl_reg == $past(rll_reg))
      else $error("Low half did not reload.");

   a_high_flag_set: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      ovf_hi |=> ctrl_reg[`SPT_CTRL_TFH])
      else $error("High flag not set.");

   a_low_flag_set: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      ovf_lo |=> ctrl_reg[`SPT_CTRL_TFL])
      else $error("Low flag not set.");

   a_flag_sticky: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (ctrl_reg[`SPT_CTRL_TFH] && !wr_ctrl) |=> ctrl_reg[`SPT_CTRL_TFH])
      else $error("High flag cleared by hardware.");

   a_low_flag_sticky: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (ctrl_reg[`SPT_CTRL_TFL] && !wr_ctrl) |=> ctrl_reg[`SPT_CTRL_TFL])
      else $error("Low flag cleared by hardware.");

   a_high_stopped: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!run_control && !(wr_en && sel_cnth)) |=> $stable(cnth_reg))
      else $error("High half moved while stopped.");

   a_high_count_up: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      s_high_step |=> cnth_reg == $past(cnth_reg) + 8'h01)
      else $error("High half not counting while running.");

   a_low_free_run: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      s_low_step |=> cntl_reg == $past(cntl_reg) + 8'h01)
      else $error("Low half not counting.");

   a_low_ignores_run: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!run_control ##0 s_low_step) |=> cntl_reg == $past(cntl_reg) + 8'h01)
      else $error("Low half stopped by run control.");

   a_split_low_hold: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!split_mode_select && !(wr_en && sel_cntl)) |=> $stable(cntl_reg))
      else $error("Low half moved outside split mode.");

   a_split_high_hold: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!split_mode_select && !(wr_en && sel_cnth)) |=> $stable(cnth_reg))
      else $error("High half moved outside split mode.");

   a_low_wrap_step: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      s_low_at_max |=> s_low_reloaded)
      else $error("Low wrap did not reload and flag.");

   a_high_wrap_step: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      s_high_at_max |=> s_high_reloaded)
      else $error("High wrap did not reload and flag.");

   a_rsvd_low_stall: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!low_clock_select && ext_clock_select == SPT_XS_RSVD && !(wr_en && sel_cntl))
         |=> $stable(cntl_reg))
      else $error("Low half counted on reserved source.");

   a_rsvd_high_stall: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!high_clock_select && ext_clock_select == SPT_XS_RSVD && !(wr_en && sel_cnth))
         |=> $stable(cnth_reg))
      else $error("High half counted on reserved source.");

   a_div12_low_gate: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!low_clock_select && ext_clock_select == SPT_XS_DIV12 && !tick_div12 &&
         !(wr_en && sel_cntl)) |=> $stable(cntl_reg))
      else $error("Low half counted between slow ticks.");

   a_div12_high_gate: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!high_clock_select && ext_clock_select == SPT_XS_DIV12 && !tick_div12 &&
         !(wr_en && sel_cnth)) |=> $stable(cnth_reg))
      else $error("High half counted between slow ticks.");

   a_rtc_low_gate: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!low_clock_select && ext_clock_select == SPT_XS_RTC8 && !tick_rtc8 &&
         !(wr_en && sel_cntl)) |=> $stable(cntl_reg))
      else $error("Low half counted without a clock edge.");

   a_cmp_low_gate: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!low_clock_select && ext_clock_select == SPT_XS_CMP0 && !cmp_rise &&
         !(wr_en && sel_cntl)) |=> $stable(cntl_reg))
      else $error("Low half counted without a comparator edge.");

   a_cmp_high_gate: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!high_clock_select && ext_clock_select == SPT_XS_CMP0 && !cmp_rise &&
         !(wr_en && sel_cnth)) |=> $stable(cnth_reg))
      else $error("High half counted without a comparator edge.");

   // An edge may only be seen once the pin level has crossed both flip-flops.
   a_rtc_sync_depth: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      rtc_rise |-> $past(rtc_clk_in, 2))
      else $error("Clock edge seen before synchronising.");

   a_cmp_sync_depth: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      cmp_rise |-> $past(cmp0_in, 2))
      else $error("Comparator edge seen before synchronising.");

   a_div8_step: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      rtc_rise |=> div8_reg == $past(div8_reg) + 3'h1)
      else $error("Divide by 8 missed an edge.");

   a_div8_hold: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !rtc_rise |=> $stable(div8_reg))
      else $error("Divide by 8 moved without an edge.");

   a_div12_range: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      div12_reg <= `SPT_DIV12_LAST)
      else $error("Divide by 12 count out of range.");

   a_div12_period: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      tick_div12 |=> !tick_div12 [*8] ##1 !tick_div12 [*3] ##1 tick_div12)
      else $error("Divide by 12 tick wrong.");

   a_irq_high: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (ovf_hi && timer_irq_enable && !(wr_en && sel_ie)) |=> irq)
      else $error("No interrupt on high overflow.");

   a_irq_low: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (ctrl_reg[`SPT_CTRL_TFL] && !ctrl_reg[`SPT_CTRL_TFH] && !low_flag_irq_enable) |-> !irq)
      else $error("Low flag interrupted while disabled.");

   a_irq_masked: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !timer_irq_enable |-> !irq)
      else $error("Interrupt raised while masked.");

   a_irq_high_level: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (timer_irq_enable && ctrl_reg[`SPT_CTRL_TFH]) |-> irq)
      else $error("High flag set but no interrupt.");

   a_irq_low_level: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (timer_irq_enable && low_flag_irq_enable && ctrl_reg[`SPT_CTRL_TFL]) |-> irq)
      else $error("Low flag enabled but no interrupt.");

   a_irq_needs_flag: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!ctrl_reg[`SPT_CTRL_TFH] && !ctrl_reg[`SPT_CTRL_TFL]) |-> !irq)
      else $error("Interrupt raised with no flag set.");

endmodule : spt_timer
`default_nettype wire

// *** spt_timer_tb.sv ***
// Self-checking bench for the split 8-bit auto-reload timer.
`include "spt_cfg.svh"
`default_nettype none
module spt_timer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import spt_pkg::*;
   logic      sys_clk = 1'b0;
   logic      rst_n = 1'b0;
   spt_addr_t addr = 4'h0;
   spt_byte_t wr_data = 8'h00;
   logic      wr_en = 1'b0;
   logic      rd_en = 1'b0;
   spt_byte_t rd_data;
   logic      rtc_clk_in = 1'b0;
   logic      cmp0_in = 1'b0;
   logic      irq;
   logic      rd_seen = 1'b0;
   spt_byte_t exp_q[$];
   bit        tol_q[$];
   int        miscompares = 0;
   int        num_checks = 0;
   spt_byte_t rl;
   spt_byte_t rh;
   // Counts after 16 source edges; the divide-by-12 phase is free, so it gets a tolerance.
   spt_byte_t src_exp[4] = '{8'h0B, 8'h02, 8'h00, 8'h10};
   always #12.5 sys_clk = ~sys_clk;
   spt_timer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rtc_clk_in(rtc_clk_in),
      .cmp0_in(cmp0_in), .irq(irq));
   task automatic chk(input string name, input spt_byte_t seen, input spt_byte_t exp,
                      input bit tol);
      num_checks++;
      if (!(seen === exp || (tol && (seen === exp - 8'h01 || seen === exp + 8'h01)))) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   task automatic wr(input spt_addr_t a, input spt_byte_t d);
      @(posedge sys_clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge sys_clk);
      wr_en   <= 1'b0;
   endtask : wr
   task automatic rd(input spt_addr_t a, input spt_byte_t e, input bit t = 1'b0);
      @(posedge sys_clk);
      addr  <= a;
      rd_en <= 1'b1;
      exp_q.push_back(e);
      tol_q.push_back(t);
      @(posedge sys_clk);
      rd_en <= 1'b0;
   endtask : rd
   task automatic irq_is(input logic e);
      @(posedge sys_clk);
      chk("irq", {7'h00, irq}, {7'h00, e}, 1'b0);
   endtask : irq_is
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         rtc_clk_in <= 1'b1;
         cmp0_in    <= 1'b1;
         repeat (4) @(posedge sys_clk);
         rtc_clk_in <= 1'b0;
         cmp0_in    <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
   endtask : pulses
   // Read data are valid only in the cycle after the strobe, so compare exactly there.
   always @(posedge sys_clk) begin
      if (rd_seen) begin
         chk("rd_data", rd_data, exp_q.pop_front(), tol_q.pop_front());
      end
      rd_seen <= rd_en;
   end
   initial begin
      void'($urandom(83));
      rl = 8'($urandom % 240);
      rh = 8'($urandom % 240);
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 9; a++) rd(4'(a), 8'h00);
      wr(4'h9, 8'h5A);
      rd(4'h9, 8'h00);
      wr(`SPT_ADDR_CLOCK_CONTROL_REG, 8'h03);
      wr(`SPT_ADDR_RLL, rl);
      wr(`SPT_ADDR_RLH, rh);
      wr(`SPT_ADDR_CTRL, 8'h08);
      wr(`SPT_ADDR_CNTH, 8'h10);
      wr(`SPT_ADDR_CNTL, 8'hFE);
      repeat (2) @(posedge sys_clk);
      rd(`SPT_ADDR_CTRL, 8'h48);
      wr(`SPT_ADDR_CTRL, 8'h40);
      rd(`SPT_ADDR_CNTL, rl + 8'h04);
      rd(`SPT_ADDR_CNTH, 8'h10);
      rd(`SPT_ADDR_CTRL, 8'h40);
      wr(`SPT_ADDR_CLOCK_CONTROL_REG, 8'h02);
      wr(`SPT_ADDR_CTRL, 8'h0E);
      wr(`SPT_ADDR_CNTH, 8'hFD);
      repeat (2) @(posedge sys_clk);
      rd(`SPT_ADDR_CTRL, 8'h8E);
      wr(`SPT_ADDR_CTRL, 8'h8A);
      rd(`SPT_ADDR_CNTH, rh + 8'h03);
      rd(`SPT_ADDR_CNTL, rl + 8'h04);
      repeat (20) @(posedge sys_clk);
      rd(`SPT_ADDR_CTRL, 8'h8A);
      wr(`SPT_ADDR_IE, 8'h01);
      irq_is(1'b1);
      wr(`SPT_ADDR_IE, 8'h00);
      irq_is(1'b0);
      wr(`SPT_ADDR_IE, 8'h01);
      wr(`SPT_ADDR_CTRL, 8'h0A);
      irq_is(1'b0);
      wr(`SPT_ADDR_CLOCK_CONTROL_REG, 8'h01);
      wr(`SPT_ADDR_CTRL, 8'h28);
      wr(`SPT_ADDR_CNTL, 8'hFE);
      repeat (2) @(posedge sys_clk);
      irq_is(1'b1);
      rd(`SPT_ADDR_CTRL, 8'h68);
      wr(`SPT_ADDR_CTRL, 8'h40);
      irq_is(1'b0);
      wr(`SPT_ADDR_CTRL, 8'h60);
      irq_is(1'b1);
      wr(`SPT_ADDR_CLOCK_CONTROL_REG, 8'h00);
      for (int x = 0; x < 4; x++) begin
         wr(`SPT_ADDR_CNTL, 8'h00);
         wr(`SPT_ADDR_CTRL, 8'h08 | 8'(x));
         pulses(16);
         repeat (6) @(posedge sys_clk);
         wr(`SPT_ADDR_CTRL, 8'(x));
         rd(`SPT_ADDR_CNTL, src_exp[x], x == 0);
      end
      repeat (2) @(posedge sys_clk);
      wrap_up();
   end
endmodule : spt_timer_tb
`default_nettype wire
